// ---- core/load_cmd_cfg.svh ----
// constants of the load command interpreter
`ifndef LOAD_CMD_CFG_SVH
`define LOAD_CMD_CFG_SVH
`define NUM_LOADS    4
`define LOAD_CMD_DGN 17'h1_FFBC
`define CLK_NS       32'h0000_0004
`define SEC_NS       32'h3B9A_CA00
`define FLASH_HALF_S 32'h0000_0001
`define INST_ALL     8'h00
`define INST_GROUP   8'hFF
`define GRP_NONE     8'hFF
`define LVL_ZERO     8'h00
`define LVL_HALF     8'h64
`define LVL_FULL     8'hC8
`define LVL_TOGGLE   8'hFA
`define LVL_MEMORY   8'hFB
`define SEC_MAX      8'hF0
`define MIN_MAX      8'hFA
`define DUR_FOREVER  8'hFF
`define MIN_BASE     10'h0EC
`define SEC_PER_MIN  10'h03C
`define MOMENTARY_S  10'h002
`define MODE_AUTO    2'b00
`define MODE_MANUAL  2'b01
`define CMD_SET      8'h00
`define CMD_ON       8'h01
`define CMD_ON_DLY   8'h02
`define CMD_OFF      8'h03
`define CMD_STOP     8'h04
`define CMD_TOGGLE   8'h05
`define CMD_MEM_OFF  8'h06
`define CMD_LOCK     8'h21
`define CMD_UNLOCK   8'h22
`define CMD_FLASH    8'h31
`define ADDR_CTRL    12'h000
`define ADDR_NACK    12'h030
`define CFG_BASE     12'h010
`define STAT_BASE    12'h020
`define CFG_RST      32'h0002_0000
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

// ---- core/load_cmd_pkg.sv ----
// types of the load command interpreter
package load_cmd_pkg;
	typedef enum logic [1:0] {
		KIND_ONOFF = 2'b00,
		KIND_TWO   = 2'b01,
		KIND_DIM   = 2'b10
	} load_kind_type;
	typedef struct packed {
		logic [16:0]     data_group_number;
		logic [7:0]      source;
		logic [7:0][7:0] data;
	} load_command_message_type;
	typedef struct packed {
		logic       valid;
		logic [7:0] source;
		logic [7:0] command;
	} nack_type;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] level;
		logic [7:0] delay;
	} exec_type;
endpackage

// ---- core/load_cmd_interp.sv ----
// load command interpreter with AXI4-Lite register access
`timescale 1ns/1ps
`include "load_cmd_cfg.svh"

// Function
// - instance byte zero addresses every load regardless of groups
// - instance byte 255 addresses only loads in the named groups
// - group byte with top bits 10 is a node group number
// - node groups 1 to 63; all-ones group byte means no group
// - level is the lowest supported level at or above the request
// - on/off load takes nonzero as on; two-level load rounds to half or full
// - level value 250 toggles the load on or off
// - level value 251 uses the stored master memory level
// - mode field 00 automatic, 01 manual; manual loads are never shed
// - interlocked command waits for identical opposite-bit command from another source
// - delay/duration byte counts whole seconds up to 240
// - values 241 to 250 count minutes, 5 to 14
// - duration 0 reverts after 2 s, 255 lasts forever
// - command 0x00 sets the requested level after the delay
// - 0x01 full on for the duration; 0x02 full on after the delay
// - 0x03 drives zero, after the delay when nonzero
// - 0x04 drives zero and ends flashing
// - 0x05 alternates between zero and the requested level
// - 0x06 saves the level to master memory then drives zero
// - 0x21 locks the instance against commands until 0x22 unlocks
// - 0x31 flashes the output between zero and full
// - unsupported command code answers with a negative acknowledgement
// - each instance reports the code of its last executed command
module load_cmd_interp #(
	parameter int unsigned TICK_CYCLES  = `SEC_NS / `CLK_NS,
	parameter int unsigned FLASH_HALF_S = `FLASH_HALF_S
) (
	input  wire logic                                 clk,
	input  wire logic                                 srst,
	input  wire logic                                 frame_valid,
	input  wire load_cmd_pkg::load_command_message_type frame,
	input  wire logic [11:0]                          s_axi_awaddr,
	input  wire logic                                 s_axi_awvalid,
	output logic                                      s_axi_awready,
	input  wire logic [31:0]                          s_axi_wdata,
	input  wire logic [3:0]                           s_axi_wstrb,
	input  wire logic                                 s_axi_wvalid,
	output logic                                      s_axi_wready,
	output logic [1:0]                                s_axi_bresp,
	output logic                                      s_axi_bvalid,
	input  wire logic                                 s_axi_bready,
	input  wire logic [11:0]                          s_axi_araddr,
	input  wire logic                                 s_axi_arvalid,
	output logic                                      s_axi_arready,
	output logic [31:0]                               s_axi_rdata,
	output logic [1:0]                                s_axi_rresp,
	output logic                                      s_axi_rvalid,
	input  wire logic                                 s_axi_rready,
	output logic [`NUM_LOADS-1:0][7:0]                load_level,
	output logic [`NUM_LOADS-1:0]                     load_manual,
	output load_cmd_pkg::nack_type                    nack
);

	////////////////////////////////////////////////////////////////
	// declarations
	logic [`NUM_LOADS-1:0][31:0] cfg_q, stat_w;
	logic [`NUM_LOADS-1:0]       match_w;
	logic [5:0]                  node_grp_q;
	logic [15:0]                 nack_info_q;
	load_cmd_pkg::nack_type      nack_q;
	logic [31:0]                 sec_cnt_q, fl_cnt_q, w_data_q, rd_d;
	logic                        tick_q, phase_q, f_take, f_sup, f_grp_ok;
	logic                        aw_hold_q, w_hold_q, do_write, wr_ok, rd_ok;
	logic [7:0]                  f_inst, f_grp, f_cmd;
	logic [1:0]                  f_ilk;
	logic [47:0]                 f_body;
	logic [11:0]                 aw_addr_q;
	logic [3:0]                  w_strb_q;

	// delay byte to seconds, zero where it names no time
	function automatic logic [9:0] secs_of(input logic [7:0] v);
		logic [9:0] m;
		m = {2'b00, v} - `MIN_BASE;
		if (v <= `SEC_MAX) begin
			secs_of = {2'b00, v};
		end else if (v <= `MIN_MAX) begin
			secs_of = 10'(m * `SEC_PER_MIN);
		end else begin
			secs_of = 10'h000;
		end
	endfunction

	// round a request up to what the load can do
	function automatic logic [7:0] round_lvl(input logic [7:0] v, input load_cmd_pkg::load_kind_type k);
		if (v == `LVL_ZERO) begin
			round_lvl = `LVL_ZERO;
		end else if (v >= `LVL_FULL || k == load_cmd_pkg::KIND_ONOFF) begin
			round_lvl = `LVL_FULL;
		end else if (k == load_cmd_pkg::KIND_TWO) begin
			round_lvl = (v <= `LVL_HALF) ? `LVL_HALF : `LVL_FULL;
		end else begin
			round_lvl = v;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// frame decode shared by all loads
	assign f_take = frame_valid && frame.data_group_number == `LOAD_CMD_DGN;
	assign f_inst = frame.data[0];
	assign f_grp  = frame.data[1];
	assign f_cmd  = frame.data[4];
	assign f_ilk  = frame.data[3][3:2];
	assign f_body = {frame.data[5], frame.data[4], frame.data[3][7:4], frame.data[3][1:0],
		2'b00, frame.data[2], frame.data[1], frame.data[0]};

	// group match: node group number only; the group bitmap is tested per load
	always_comb begin
		if (f_grp == `GRP_NONE) begin
			f_grp_ok = 1'b0;
		end else if (f_grp[7:6] == 2'b10) begin
			f_grp_ok = f_grp[5:0] != 6'h00 && f_grp[5:0] == node_grp_q;
		end else begin
			f_grp_ok = 1'b0;
		end
	end

	// codes this node carries out
	always_comb begin
		unique case (f_cmd)
			`CMD_SET, `CMD_ON, `CMD_ON_DLY, `CMD_OFF, `CMD_STOP, `CMD_TOGGLE,
			`CMD_MEM_OFF, `CMD_LOCK, `CMD_UNLOCK, `CMD_FLASH: f_sup = 1'b1;
			default: f_sup = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// seconds timebase and flash phase
	always_ff @(posedge clk) begin
		if (srst) begin
			sec_cnt_q <= 32'h0000_0000;
			tick_q    <= 1'b0;
		end else begin
			tick_q    <= sec_cnt_q == TICK_CYCLES - 1;
			sec_cnt_q <= (sec_cnt_q == TICK_CYCLES - 1) ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
		end
	end

	// flash phase flips every half-period
	always_ff @(posedge clk) begin
		if (srst) begin
			fl_cnt_q <= 32'h0000_0000;
			phase_q  <= 1'b0;
		end else if (tick_q) begin
			if (fl_cnt_q >= FLASH_HALF_S - 1) begin
				fl_cnt_q <= 32'h0000_0000;
				phase_q  <= !phase_q;
			end else begin
				fl_cnt_q <= fl_cnt_q + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// per-load state
	for (genvar i = 0; i < `NUM_LOADS; i++) begin : g_load
		load_cmd_pkg::load_kind_type kind;
		load_cmd_pkg::exec_type      ex, pend_q;
		logic                        ex_v, match, hit, go, hold, delayed, expire;
		logic                        tmr_act_q, tdur_q, lock_q, flash_q, manual_q, ilk_v_q;
		logic [9:0]                  dsecs, dur, tmr_q;
		logic [7:0]                  req, lvl_q, mem_q, last_q, restore_q, out_q, ilk_src_q;
		logic [1:0]                  ilk_bits_q;
		logic [47:0]                 ilk_body_q;

		// addressing, interlock pairing and scheduling
		always_comb begin
			kind  = load_cmd_pkg::load_kind_type'(cfg_q[i][17:16]);
			match = f_take && (f_inst == `INST_ALL
				|| (f_inst == `INST_GROUP && (f_grp_ok || (f_grp[7:6] != 2'b10 && f_grp != `GRP_NONE
				&& (f_grp & cfg_q[i][15:8]) != 8'h00)))
				|| (f_inst != `INST_GROUP && f_inst == cfg_q[i][7:0]));
			hit   = ilk_v_q && ilk_src_q != frame.source && (ilk_bits_q ^ f_ilk) == 2'b11
				&& ilk_body_q == f_body;
			go    = match && f_sup && !(lock_q && f_cmd != `CMD_LOCK && f_cmd != `CMD_UNLOCK)
				&& (f_ilk == 2'b00 || hit);
			hold  = match && f_sup && !(lock_q && f_cmd != `CMD_UNLOCK) && f_ilk != 2'b00 && !hit;
			dsecs = secs_of(frame.data[5]);
			dur   = (frame.data[5] == `LVL_ZERO) ? `MOMENTARY_S : dsecs;
			delayed = go && dsecs != 10'h000
				&& (f_cmd == `CMD_SET || f_cmd == `CMD_ON_DLY || f_cmd == `CMD_OFF);
			expire = tick_q && tmr_act_q && tmr_q == 10'h001;
			ex_v = 1'b1;
			if (go && !delayed) begin
				ex = '{cmd: f_cmd, level: frame.data[2], delay: frame.data[5]};
			end else if (expire && !tdur_q && !delayed) begin
				ex = pend_q;
			end else begin
				ex   = pend_q;
				ex_v = 1'b0;
			end
			if (ex.level == `LVL_TOGGLE) begin
				req = (lvl_q != `LVL_ZERO) ? `LVL_ZERO : `LVL_FULL;
			end else if (ex.level == `LVL_MEMORY) begin
				req = mem_q;
			end else begin
				req = round_lvl(ex.level, kind);
			end
		end

		// interlock holding slot
		always_ff @(posedge clk) begin
			if (srst) begin
				ilk_v_q    <= 1'b0;
				ilk_bits_q <= 2'b00;
				ilk_src_q  <= 8'h00;
				ilk_body_q <= 48'h0000_0000_0000;
			end else if (hold) begin
				ilk_v_q    <= 1'b1;
				ilk_bits_q <= f_ilk;
				ilk_src_q  <= frame.source;
				ilk_body_q <= f_body;
			end else if (go) begin
				ilk_v_q <= 1'b0;
			end
		end

		// delay and duration timer
		always_ff @(posedge clk) begin
			if (srst) begin
				tmr_q     <= 10'h000;
				tmr_act_q <= 1'b0;
				tdur_q    <= 1'b0;
				pend_q    <= '0;
				restore_q <= `LVL_ZERO;
			end else begin
				if (tick_q && tmr_act_q) begin
					tmr_q <= tmr_q - 10'h001;
				end
				if (expire || (go && f_cmd != `CMD_LOCK && f_cmd != `CMD_UNLOCK)) begin
					tmr_act_q <= 1'b0;
				end
				if (delayed) begin
					tmr_act_q <= 1'b1;
					tdur_q    <= 1'b0;
					tmr_q     <= dsecs;
					pend_q    <= '{cmd: f_cmd, level: frame.data[2], delay: frame.data[5]};
				end else if (go && f_cmd == `CMD_ON && frame.data[5] != `DUR_FOREVER && dur != 10'h000) begin
					tmr_act_q <= 1'b1;
					tdur_q    <= 1'b1;
					tmr_q     <= dur;
					restore_q <= (tmr_act_q && tdur_q) ? restore_q : lvl_q;
				end
			end
		end

		// level, memory, lock, flash and mode
		always_ff @(posedge clk) begin
			if (srst) begin
				lvl_q    <= `LVL_ZERO;
				mem_q    <= `LVL_FULL;
				last_q   <= 8'hFF;
				lock_q   <= 1'b0;
				flash_q  <= 1'b0;
				manual_q <= 1'b0;
			end else begin
				if (expire && tdur_q) begin
					lvl_q <= restore_q;
				end
				if (go && (frame.data[3][1:0] == `MODE_AUTO || frame.data[3][1:0] == `MODE_MANUAL)) begin
					manual_q <= frame.data[3][1:0] == `MODE_MANUAL;
				end
				if (ex_v) begin
					last_q <= ex.cmd;
					if (ex.cmd != `CMD_LOCK && ex.cmd != `CMD_UNLOCK) begin
						flash_q <= 1'b0;
					end
					unique case (ex.cmd)
						`CMD_SET: lvl_q <= req;
						`CMD_ON, `CMD_ON_DLY: lvl_q <= `LVL_FULL;
						`CMD_OFF, `CMD_STOP: lvl_q <= `LVL_ZERO;
						`CMD_TOGGLE: lvl_q <= (lvl_q != `LVL_ZERO) ? `LVL_ZERO : req;
						`CMD_LOCK: lock_q <= 1'b1;
						`CMD_UNLOCK: lock_q <= 1'b0;
						`CMD_FLASH: flash_q <= 1'b1;
						default: begin
							mem_q <= lvl_q;
							lvl_q <= `LVL_ZERO;
						end
					endcase
				end
			end
		end

		// driven output level
		always_ff @(posedge clk) begin
			if (srst) begin
				out_q <= `LVL_ZERO;
			end else begin
				out_q <= flash_q ? (phase_q ? `LVL_FULL : `LVL_ZERO) : lvl_q;
			end
		end

		assign match_w[i]     = match;
		assign load_level[i]  = out_q;
		assign load_manual[i] = manual_q;
		assign stat_w[i]      = {mem_q, 3'b000, tmr_act_q, manual_q, flash_q, ilk_v_q, lock_q, last_q, lvl_q};
	end

	////////////////////////////////////////////////////////////////
	// negative acknowledgement for unknown codes
	always_ff @(posedge clk) begin
		if (srst) begin
			nack_q      <= '0;
			nack_info_q <= 16'h0000;
		end else begin
			nack_q.valid   <= f_take && !f_sup && match_w != '0;
			nack_q.source  <= frame.source;
			nack_q.command <= f_cmd;
			if (f_take && !f_sup && match_w != '0) begin
				nack_info_q <= {frame.source, f_cmd};
			end
		end
	end

	assign nack = nack_q;

	////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign wr_ok    = aw_addr_q == `ADDR_CTRL || {aw_addr_q[11:4], 4'h0} == `CFG_BASE;

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_addr_q     <= 12'h000;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// writable registers, byte lanes honoured
	always_ff @(posedge clk) begin
		if (srst) begin
			node_grp_q <= 6'h00;
			cfg_q      <= {`NUM_LOADS{`CFG_RST}};
		end else if (do_write) begin
			if (aw_addr_q == `ADDR_CTRL && w_strb_q[0]) begin
				node_grp_q <= w_data_q[5:0];
			end
			if ({aw_addr_q[11:4], 4'h0} == `CFG_BASE) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb_q[b]) begin
						cfg_q[aw_addr_q[3:2]][b*8 +: 8] <= w_data_q[b*8 +: 8];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == `ADDR_CTRL) begin
			rd_d = {26'h000_0000, node_grp_q};
		end else if (s_axi_araddr == `ADDR_NACK) begin
			rd_d = {16'h0000, nack_info_q};
		end else if ({s_axi_araddr[11:4], 4'h0} == `CFG_BASE) begin
			rd_d = cfg_q[s_axi_araddr[3:2]];
		end else if ({s_axi_araddr[11:4], 4'h0} == `STAT_BASE) begin
			rd_d = stat_w[s_axi_araddr[3:2]];
		end else begin
			rd_d  = 32'h0000_0000;
			rd_ok = 1'b0;
		end
	end

	// one read at a time, answered the cycle after the address
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_d;
			s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// ---- verif/load_cmd_interp_checker.sv ----
// assertions on the ports of the load command interpreter
`timescale 1ns/1ps
`include "load_cmd_cfg.svh"

module load_cmd_interp_checker (
	input wire logic                                   clk,
	input wire logic                                   srst,
	input wire logic                                   frame_valid,
	input wire load_cmd_pkg::load_command_message_type frame,
	input wire logic                                   s_axi_awvalid,
	input wire logic                                   s_axi_awready,
	input wire logic                                   s_axi_wvalid,
	input wire logic                                   s_axi_wready,
	input wire logic [1:0]                             s_axi_bresp,
	input wire logic                                   s_axi_bvalid,
	input wire logic                                   s_axi_bready,
	input wire logic                                   s_axi_arvalid,
	input wire logic                                   s_axi_arready,
	input wire logic [31:0]                            s_axi_rdata,
	input wire logic [1:0]                             s_axi_rresp,
	input wire logic                                   s_axi_rvalid,
	input wire logic                                   s_axi_rready,
	input wire logic [`NUM_LOADS-1:0][7:0]             load_level,
	input wire load_cmd_pkg::nack_type                 nack
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////
	// reply to unsupported codes
	a_nack_pulse: assert property (nack.valid && !frame_valid |=> !nack.valid)
		else $error("nack valid held beyond one cycle");
	a_nack_cause: assert property (nack.valid |-> $past(frame_valid) && nack.command == $past(frame.data[4])
		&& nack.source == $past(frame.source)) else $error("nack not tied to the previous frame");
	a_unsup_nack: assert property (frame_valid && frame.data_group_number == `LOAD_CMD_DGN
		&& frame.data[0] == `INST_ALL && frame.data[4] == 8'h07 |=> nack.valid) else $error("no nack");

	////////////////////////////////////////////////////////////
	// register bus handshakes
	a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");

	// every level stays inside the 0 to 100 percent range
	for (genvar i = 0; i < `NUM_LOADS; i++) begin : g_rng
		a_level_range: assert property (load_level[i] <= `LVL_FULL)
			else $error("level above full");
	end

	// main scenarios
	c_nack: cover property (nack.valid);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `RESP_SLVERR);
endmodule

bind load_cmd_interp load_cmd_interp_checker u_load_cmd_interp_checker (.*);

// ---- verif/load_cmd_sender.sv ----
// network node model that sends load command frames
`timescale 1ns/1ps
`include "load_cmd_cfg.svh"

module load_cmd_sender (
	input  wire logic                              clk,
	output logic                                   frame_valid,
	output load_cmd_pkg::load_command_message_type frame
);
	// idle bus at start
	initial begin
		frame_valid = 1'b0;
		frame = '0;
	end

	// one frame for one cycle; released contents are inverted so stale data never looks valid
	task automatic send(input logic [7:0] inst, lvl, code, dly = 8'h00, b3 = 8'h00, grp = 8'hFF, src = 8'h01);
		@(posedge clk);
		frame_valid <= 1'b1;
		frame.data_group_number <= `LOAD_CMD_DGN;
		frame.source <= src;
		frame.data <= {8'h00, 8'h00, dly, code, b3, lvl, grp, inst};
		@(posedge clk);
		frame_valid <= 1'b0;
		frame <= ~frame;
	endtask
endmodule

// ---- verif/load_command_message_interpreter_tb.sv ----
// self-checking bench for the load command interpreter
`timescale 1ns/1ps
`include "load_cmd_cfg.svh"

module load_command_message_interpreter_tb;
	logic                                   clk, srst, frame_valid;
	load_cmd_pkg::load_command_message_type frame;
	logic [11:0]                            s_axi_awaddr, s_axi_araddr;
	logic [31:0]                            s_axi_wdata, s_axi_rdata;
	logic [3:0]                             s_axi_wstrb;
	logic [1:0]                             s_axi_bresp, s_axi_rresp;
	logic                                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                                   s_axi_rvalid, s_axi_rready;
	logic [`NUM_LOADS-1:0][7:0]             load_level;
	logic [`NUM_LOADS-1:0]                  load_manual;
	load_cmd_pkg::nack_type                 nack;
	int                                     err_total, checks;
	logic [31:0]                            cfg [4] = '{32'h0000_0101, 32'h0001_0202, 32'h0002_0403, 32'h0002_0804};

	load_cmd_interp #(.TICK_CYCLES(32'h0000_000A), .FLASH_HALF_S(32'h0000_0001)) u_load_cmd_interp (.*);
	load_cmd_sender u_src (.clk(clk), .frame_valid(frame_valid), .frame(frame));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////
	// compare, report and bus tasks
	task automatic ck(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic to_out(input string n);
		ck(n, 32'h0000_0001, 32'h0000_0000);
		tally_and_finish();
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		if (s_axi_bvalid !== 1'b1) to_out("write timeout");
		ck("bresp", 32'(r), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, e, input logic [1:0] r);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		if (s_axi_rvalid !== 1'b1) to_out("read timeout");
		ck("rdata", e, s_axi_rdata & m);
		ck("rresp", 32'(r), 32'(s_axi_rresp));
	endtask
	// levels show two edges after the frame
	task automatic lv(input logic [7:0] e0, e1, e2, e3);
		@(posedge clk);
		#1;
		ck("level", {e3, e2, e1, e0}, load_level);
	endtask
	task automatic wl(input int i, input logic [7:0] e, input int mx);
		int n;
		n = 0;
		while (load_level[i] !== e && n < mx) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (load_level[i] !== e) to_out("level wait");
		ck("level wait", 32'(e), 32'(load_level[i]));
	endtask
	task automatic hold(input int i, input logic [7:0] e, input int c);
		repeat (c) @(posedge clk);
		#1;
		ck("level hold", 32'(e), 32'(load_level[i]));
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		err_total = 0;
		checks = 0;
		srst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rd(`CFG_BASE, 32'hFFFF_FFFF, `CFG_RST, `RESP_OKAY);
		rd(`STAT_BASE, 32'hFF00_FFFF, 32'hC800_FF00, `RESP_OKAY);
		rd(12'h040, 32'hFFFF_FFFF, 32'h0000_0000, `RESP_SLVERR);
		wr(`STAT_BASE, 32'h0000_0000, `RESP_SLVERR);
		wr(`ADDR_CTRL, 32'h0000_0005, `RESP_OKAY);
		for (int i = 0; i < 4; i++) wr(`CFG_BASE + 12'(4 * i), cfg[i], `RESP_OKAY);
		rd(12'h014, 32'hFFFF_FFFF, cfg[1], `RESP_OKAY);
		$display("test registers done");
		u_src.send(`INST_ALL, 8'h0A, `CMD_SET);
		lv(8'hC8, 8'h64, 8'h0A, 8'h0A);
		u_src.send(8'h02, 8'h65, `CMD_SET);
		lv(8'hC8, 8'hC8, 8'h0A, 8'h0A);
		u_src.send(`INST_GROUP, 8'h00, `CMD_OFF, 8'h00, 8'h00, 8'h02);
		lv(8'hC8, 8'h00, 8'h0A, 8'h0A);
		u_src.send(`INST_GROUP, 8'hC8, `CMD_SET, 8'h00, 8'h00, `GRP_NONE);
		lv(8'hC8, 8'h00, 8'h0A, 8'h0A);
		u_src.send(`INST_GROUP, 8'h00, `CMD_OFF, 8'h00, 8'h00, 8'h86);
		lv(8'hC8, 8'h00, 8'h0A, 8'h0A);
		u_src.send(`INST_GROUP, 8'h00, `CMD_OFF, 8'h00, 8'h00, 8'h85);
		lv(8'h00, 8'h00, 8'h00, 8'h00);
		$display("test addressing done");
		u_src.send(8'h03, `LVL_TOGGLE, `CMD_SET);
		lv(8'h00, 8'h00, 8'hC8, 8'h00);
		u_src.send(8'h03, `LVL_TOGGLE, `CMD_SET);
		lv(8'h00, 8'h00, 8'h00, 8'h00);
		u_src.send(8'h03, 8'h50, `CMD_TOGGLE);
		lv(8'h00, 8'h00, 8'h50, 8'h00);
		u_src.send(8'h03, 8'h50, `CMD_TOGGLE);
		lv(8'h00, 8'h00, 8'h00, 8'h00);
		u_src.send(8'h03, 8'h32, `CMD_SET);
		u_src.send(8'h03, 8'h00, `CMD_MEM_OFF);
		lv(8'h00, 8'h00, 8'h00, 8'h00);
		rd(12'h028, 32'hFF00_FF00, 32'h3200_0600, `RESP_OKAY);
		u_src.send(8'h03, `LVL_MEMORY, `CMD_SET);
		lv(8'h00, 8'h00, 8'h32, 8'h00);
		u_src.send(8'h04, 8'h14, `CMD_SET, 8'h00, 8'h01);
		lv(8'h00, 8'h00, 8'h32, 8'h14);
		ck("manual", 32'h0000_0008, 32'(load_manual));
		u_src.send(8'h04, 8'h14, `CMD_SET);
		lv(8'h00, 8'h00, 8'h32, 8'h14);
		ck("manual", 32'h0000_0000, 32'(load_manual));
		$display("test levels done");
		u_src.send(8'h03, 8'h00, `CMD_LOCK);
		rd(12'h028, 32'h0001_0000, 32'h0001_0000, `RESP_OKAY);
		u_src.send(8'h03, 8'h1E, `CMD_SET);
		lv(8'h00, 8'h00, 8'h32, 8'h14);
		u_src.send(8'h03, 8'h00, `CMD_UNLOCK);
		u_src.send(8'h03, 8'h1E, `CMD_SET);
		lv(8'h00, 8'h00, 8'h1E, 8'h14);
		rd(12'h028, 32'h0001_FF00, 32'h0000_0000, `RESP_OKAY);
		u_src.send(8'h04, 8'h00, `CMD_ON, `DUR_FOREVER, 8'h04, `GRP_NONE, 8'h10);
		rd(12'h02C, 32'h0002_0000, 32'h0002_0000, `RESP_OKAY);
		u_src.send(8'h04, 8'h00, `CMD_ON, `DUR_FOREVER, 8'h08, `GRP_NONE, 8'h10);
		lv(8'h00, 8'h00, 8'h1E, 8'h14);
		u_src.send(8'h04, 8'h00, `CMD_ON, `DUR_FOREVER, 8'h04, `GRP_NONE, 8'h20);
		lv(8'h00, 8'h00, 8'h1E, 8'hC8);
		$display("test lock and interlock done");
		u_src.send(8'h04, 8'h00, `CMD_OFF, 8'h03);
		hold(3, 8'hC8, 15);
		wl(3, 8'h00, 30);
		u_src.send(8'h04, 8'h00, `CMD_ON_DLY, 8'h03);
		hold(3, 8'h00, 15);
		wl(3, 8'hC8, 30);
		u_src.send(8'h04, 8'h00, `CMD_ON_DLY, 8'h03);
		u_src.send(8'h04, 8'h00, `CMD_OFF);
		hold(3, 8'h00, 40);
		u_src.send(8'h04, 8'h00, `CMD_ON);
		hold(3, 8'hC8, 5);
		wl(3, 8'h00, 30);
		u_src.send(8'h04, 8'hC8, `CMD_SET);
		u_src.send(8'h04, 8'h00, `CMD_OFF, 8'hF1);
		hold(3, 8'hC8, 2900);
		wl(3, 8'h00, 200);
		$display("test timers done");
		u_src.send(8'h03, 8'h00, `CMD_FLASH);
		wl(2, 8'hC8, 30);
		wl(2, 8'h00, 30);
		wl(2, 8'hC8, 30);
		u_src.send(8'h03, 8'h00, `CMD_STOP);
		lv(8'h00, 8'h00, 8'h00, 8'h00);
		hold(2, 8'h00, 30);
		$display("test flash done");
		u_src.send(`INST_ALL, 8'h00, 8'h07, 8'h00, 8'h00, `GRP_NONE, 8'h33);
		#1;
		ck("nack", 32'h0001_3307, 32'(nack));
		@(posedge clk);
		#1;
		ck("nack valid", 32'h0000_0000, 32'(nack.valid));
		rd(`ADDR_NACK, 32'h0000_FFFF, 32'h0000_3307, `RESP_OKAY);
		$display("test nack done");
		tally_and_finish();
	end
endmodule
